// *** mapc_consts.vh ***
// Constants for the mixed and always-on pin control block
`ifndef MAPC_CONSTS_VH
`define MAPC_CONSTS_VH
// Port controller register offsets (byte addresses)
`define MAPC_OFS_DATA 12'h000
`define MAPC_OFS_OUT_VALUE 12'h004
`define MAPC_OFS_OE_SET 12'h010
`define MAPC_OFS_OE_CLR 12'h014
// Always-on control register offsets
`define MAPC_OFS_ANALOG_MODE 12'h000
`define MAPC_OFS_MIXED_PULL 12'h004
`define MAPC_OFS_AON_ROUTE 12'h008
`define MAPC_OFS_AON_PULL_DIS 12'h00c
`define MAPC_OFS_WAKE_ENABLE 12'h010
// Register select codes
`define MAPC_SEL_CTRL2 2'h0
`define MAPC_SEL_CTRL3 2'h1
`define MAPC_SEL_AON 2'h2
// Pin counts and bit indices
`define MAPC_MS_PINS 4
`define MAPC_AO_PINS 3
`define MAPC_MS_BIT0 15
`define MAPC_AO_BIT0 15
// Pull register fields
`define MAPC_PULL_DIS_HI 7
`define MAPC_PULL_DIS_LO 4
`define MAPC_PULL_DIR_HI 3
`define MAPC_PULL_DIR_LO 0
// Reset values
`define MAPC_RST_ANALOG_MODE 4'hf
`define MAPC_RST_MIXED_PULL 8'hf0
`define MAPC_RST_AON_ROUTE 6'h00
`define MAPC_RST_AON_PULL_DIS 3'h0
`define MAPC_RST_WAKE_ENABLE 3'h1
`define MAPC_RST_OE 16'h0000
`define MAPC_RST_OUT_VALUE 16'h0000
`endif

// *** mapc_sync3.v ***
// Three-stage pad input synchroniser with agreement filter
`timescale 1ns/1ns
module mapc_sync3 #(
    parameter W = 16
) (
    // Clock and reset
    input wire i_clk,
    input wire i_rst,
    // Raw and filtered levels
    input wire [W-1:0] i_raw,
    output reg [W-1:0] o_level
);
    reg [W-1:0] stage1;
    reg [W-1:0] stage2;
    reg [W-1:0] stage3;
    genvar g;

    // Stage one feeds only stage two, to keep metastability contained
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            stage1 <= {W{1'b0}};
            stage2 <= {W{1'b0}};
            stage3 <= {W{1'b0}};
        end else begin
            stage1 <= i_raw;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // Level changes only when stages two and three agree
    generate
        for (g = 0; g < W; g = g + 1) begin : g_bit
            always @(posedge i_clk or posedge i_rst) begin
                if (i_rst) begin
                    o_level[g] <= 1'b0;
                end else if (stage2[g] == stage3[g]) begin
                    o_level[g] <= stage3[g];
                end
            end
        end
    endgenerate
endmodule // mapc_sync3

// *** mapc_pin_ctrl.v ***
// Pad control for the mixed-signal and always-on pin groups
`timescale 1ns/1ns
`include "mapc_consts.vh"

// Operation
// - Mixed pads reset to analog, pull off
// - Per-pin analog select bit, set by default
// - Mixed pins on third controller, pin0 bit15
// - Set write makes digital mixed pin output
// - Clear write makes input; data reads pad
// - Pull field: disable 7:4, direction 3:0
// - Mixed pull independent of direction
// - Always-on pads reset to input, pull-up
// - Always-on pin0 wake source after reset
// - Two-bit route field, zero means port
// - Nonzero route hands pad to peripheral
// - Always-on pins on second controller, 15/14/13
// - Set write makes port-routed always-on pin output
// - Clear write makes input; data reads pad
// - One pull-disable bit, pull-up only
// - Always-on pull-up independent of direction
module mapc_pin_ctrl (
    // Clock and reset
    input wire i_clk,
    input wire i_rst,
    // Register port
    input wire [1:0] i_sel,
    input wire [11:0] i_addr,
    input wire i_wr,
    input wire i_rd,
    input wire [31:0] i_wdata,
    output reg [31:0] o_rdata,
    // Mixed-signal pads
    input wire [3:0] i_ms_pad,
    output wire [3:0] o_ms_pad,
    output wire [3:0] o_ms_pad_oe_n,
    output wire [3:0] o_ms_analog_en,
    output wire [3:0] o_ms_pull_up,
    output wire [3:0] o_ms_pull_down,
    // Always-on pads
    input wire [2:0] i_ao_pad,
    output wire [2:0] o_ao_pad,
    output wire [2:0] o_ao_pad_oe_n,
    output wire [2:0] o_ao_pull_up,
    output wire [2:0] o_ao_wake_en,
    // Always-on peripheral routing
    output wire [5:0] o_ao_route,
    input wire [2:0] i_periph_out,
    input wire [2:0] i_periph_oe,
    output wire [2:0] o_periph_in
);
    // Port controller state
    reg [15:0] ctrl2_oe;
    reg [15:0] ctrl2_out;
    reg [15:0] ctrl3_oe;
    reg [15:0] ctrl3_out;
    // Always-on configuration
    reg [3:0] analog_mode;
    reg [7:0] mixed_pull;
    reg [5:0] ao_route;
    reg [2:0] ao_pull_dis;
    reg [2:0] wake_enable;
    // Pad sampling
    wire [15:0] ctrl2_raw;
    wire [15:0] ctrl3_raw;
    wire [15:0] ctrl2_data;
    wire [15:0] ctrl3_data;
    wire [2:0] ao_level;
    reg [31:0] next_rdata;
    genvar g;

    wire wr2 = i_wr && (i_sel == `MAPC_SEL_CTRL2);
    wire wr3 = i_wr && (i_sel == `MAPC_SEL_CTRL3);
    wire wra = i_wr && (i_sel == `MAPC_SEL_AON);

    // Direction and output value, per controller; zero bits in set and clear writes leave pins alone
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl2_oe <= `MAPC_RST_OE;
            ctrl2_out <= `MAPC_RST_OUT_VALUE;
            ctrl3_oe <= `MAPC_RST_OE;
            ctrl3_out <= `MAPC_RST_OUT_VALUE;
        end else begin
            if (wr2 && i_addr == `MAPC_OFS_OE_SET) begin
                ctrl2_oe <= ctrl2_oe | i_wdata[15:0];
            end
            if (wr2 && i_addr == `MAPC_OFS_OE_CLR) begin
                ctrl2_oe <= ctrl2_oe & ~i_wdata[15:0];
            end
            if (wr2 && i_addr == `MAPC_OFS_OUT_VALUE) begin
                ctrl2_out <= i_wdata[15:0];
            end
            if (wr3 && i_addr == `MAPC_OFS_OE_SET) begin
                ctrl3_oe <= ctrl3_oe | i_wdata[15:0];
            end
            if (wr3 && i_addr == `MAPC_OFS_OE_CLR) begin
                ctrl3_oe <= ctrl3_oe & ~i_wdata[15:0];
            end
            if (wr3 && i_addr == `MAPC_OFS_OUT_VALUE) begin
                ctrl3_out <= i_wdata[15:0];
            end
        end
    end

    // Always-on configuration registers
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            analog_mode <= `MAPC_RST_ANALOG_MODE;
            mixed_pull <= `MAPC_RST_MIXED_PULL;
            ao_route <= `MAPC_RST_AON_ROUTE;
            ao_pull_dis <= `MAPC_RST_AON_PULL_DIS;
            wake_enable <= `MAPC_RST_WAKE_ENABLE;
        end else if (wra) begin
            case (i_addr)
                `MAPC_OFS_ANALOG_MODE: analog_mode <= i_wdata[3:0];
                `MAPC_OFS_MIXED_PULL: mixed_pull <= i_wdata[7:0];
                `MAPC_OFS_AON_ROUTE: ao_route <= i_wdata[5:0];
                `MAPC_OFS_AON_PULL_DIS: ao_pull_dis <= i_wdata[2:0];
                `MAPC_OFS_WAKE_ENABLE: wake_enable <= i_wdata[2:0];
                default: ;
            endcase
        end
    end

    // Mixed-signal pads: pin y sits at bit 15-y of the third controller
    generate
        for (g = 0; g < `MAPC_MS_PINS; g = g + 1) begin : g_ms
            localparam integer N = `MAPC_MS_BIT0 - g;
            wire dig = ~analog_mode[g];
            wire dis = mixed_pull[`MAPC_PULL_DIS_LO + g];
            wire dir = mixed_pull[`MAPC_PULL_DIR_LO + g];
            // Analog pins never drive, whatever the controller holds
            assign o_ms_pad_oe_n[g] = ~(dig & ctrl3_oe[N]);
            assign o_ms_pad[g] = ctrl3_out[N];
            assign o_ms_analog_en[g] = analog_mode[g];
            // Pull ignores direction on purpose
            assign o_ms_pull_up[g] = ~dis & ~dir;
            assign o_ms_pull_down[g] = ~dis & dir;
            assign ctrl3_raw[N] = i_ms_pad[g];
        end
        for (g = 0; g < `MAPC_AO_PINS; g = g + 1) begin : g_ao
            localparam integer N = `MAPC_AO_BIT0 - g;
            wire [1:0] rsel = ao_route[2*g+1:2*g];
            wire port = (rsel == 2'h0);
            // Peripheral takes the pad whenever the route is nonzero
            assign o_ao_pad_oe_n[g] = port ? ~ctrl2_oe[N] : ~i_periph_oe[g];
            assign o_ao_pad[g] = port ? ctrl2_out[N] : i_periph_out[g];
            assign o_periph_in[g] = port ? 1'b0 : ao_level[g];
            assign o_ao_pull_up[g] = ~ao_pull_dis[g];
            assign ctrl2_raw[N] = i_ao_pad[g];
            assign ao_level[g] = ctrl2_data[N];
        end
    endgenerate

    // Unused controller bits read low
    assign ctrl3_raw[15-`MAPC_MS_PINS:0] = {(16-`MAPC_MS_PINS){1'b0}};
    assign ctrl2_raw[15-`MAPC_AO_PINS:0] = {(16-`MAPC_AO_PINS){1'b0}};
    assign o_ao_route = ao_route;
    assign o_ao_wake_en = wake_enable;

    // Pads are asynchronous; sample every pin even when driving
    mapc_sync3 #(.W(32)) u_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_raw({ctrl3_raw, ctrl2_raw}),
        .o_level({ctrl3_data, ctrl2_data})
    );

    // Read mux
    always @* begin
        next_rdata = 32'h00000000;
        case (i_sel)
            `MAPC_SEL_CTRL2, `MAPC_SEL_CTRL3: begin
                case (i_addr)
                    `MAPC_OFS_DATA: next_rdata[15:0] =
                        (i_sel == `MAPC_SEL_CTRL2) ? ctrl2_data : ctrl3_data;
                    `MAPC_OFS_OUT_VALUE: next_rdata[15:0] =
                        (i_sel == `MAPC_SEL_CTRL2) ? ctrl2_out : ctrl3_out;
                    `MAPC_OFS_OE_SET, `MAPC_OFS_OE_CLR: next_rdata[15:0] =
                        (i_sel == `MAPC_SEL_CTRL2) ? ctrl2_oe : ctrl3_oe;
                    default: next_rdata = 32'h00000000;
                endcase
            end
            `MAPC_SEL_AON: begin
                case (i_addr)
                    `MAPC_OFS_ANALOG_MODE: next_rdata[3:0] = analog_mode;
                    `MAPC_OFS_MIXED_PULL: next_rdata[7:0] = mixed_pull;
                    `MAPC_OFS_AON_ROUTE: next_rdata[5:0] = ao_route;
                    `MAPC_OFS_AON_PULL_DIS: next_rdata[2:0] = ao_pull_dis;
                    `MAPC_OFS_WAKE_ENABLE: next_rdata[2:0] = wake_enable;
                    default: next_rdata = 32'h00000000;
                endcase
            end
            default: next_rdata = 32'h00000000;
        endcase
    end

    // Registered read data, taken on the read strobe
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= 32'h00000000;
        end else if (i_rd) begin
            o_rdata <= next_rdata;
        end
    end
endmodule // mapc_pin_ctrl

// *** mapc_chk.sv ***
// Assertion checker for the mixed and always-on pin control block
`timescale 1ns/1ns
module mapc_chk (
    // Clock, reset and register port
    input wire i_clk, i_rst, i_wr, i_rd,
    input wire [1:0] i_sel,
    input wire [11:0] i_addr,
    input wire [31:0] i_wdata, o_rdata,
    // Pads and routing
    input wire [3:0] i_ms_pad, o_ms_pad_oe_n, o_ms_analog_en, o_ms_pull_up, o_ms_pull_down,
    input wire [2:0] o_ao_pad, o_ao_pad_oe_n, o_ao_pull_up, o_ao_wake_en,
    input wire [2:0] i_periph_out, i_periph_oe,
    input wire [5:0] o_ao_route
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // Write decode per register group
    wire w_c2 = i_wr && i_sel == 2'h0;
    wire w_c3 = i_wr && i_sel == 2'h1;
    wire w_aon = i_wr && i_sel == 2'h2;
    wire w_oe = i_addr == 12'h010 || i_addr == 12'h014;
    // Data read needs a settled pad, since the synchroniser lags by several cycles
    sequence s_pad_steady; $stable(i_ms_pad[0]) [*6]; endsequence
    sequence s_read_data; i_rd && i_sel == 2'h1 && i_addr == 12'h000; endsequence
    property p_rst_ms; $fell(i_rst) |-> o_ms_analog_en == 4'hf && o_ms_pad_oe_n == 4'hf
        && (o_ms_pull_up | o_ms_pull_down) == 4'h0; endproperty
    a_rst_ms: assert property (p_rst_ms) else $error("mixed pads wrong after reset");
    property p_rst_ao; $fell(i_rst) |-> o_ao_pad_oe_n == 3'h7 && o_ao_pull_up == 3'h7; endproperty
    a_rst_ao: assert property (p_rst_ao) else $error("always-on pads wrong after reset");
    property p_rst_wake; $fell(i_rst) |-> o_ao_wake_en == 3'h1; endproperty
    a_rst_wake: assert property (p_rst_wake) else $error("wake enable wrong after reset");
    property p_analog; w_aon && i_addr == 12'h000 |=> o_ms_analog_en == $past(i_wdata[3:0]); endproperty
    a_analog: assert property (p_analog) else $error("analog select not applied");
    property p_pull; w_aon && i_addr == 12'h004 |=> o_ms_pull_up == ~($past(i_wdata[7:4])
        | $past(i_wdata[3:0])) && o_ms_pull_down == (~$past(i_wdata[7:4]) & $past(i_wdata[3:0]));
    endproperty
    a_pull: assert property (p_pull) else $error("mixed pull decode wrong");
    property p_ms_set; w_c3 && i_addr == 12'h010 && i_wdata[15] && !o_ms_analog_en[0]
        |=> !o_ms_pad_oe_n[0]; endproperty
    a_ms_set: assert property (p_ms_set) else $error("mixed pin not driving");
    property p_ms_clr; w_c3 && i_addr == 12'h014 && i_wdata[15] |=> o_ms_pad_oe_n[0]; endproperty
    a_ms_clr: assert property (p_ms_clr) else $error("mixed pin still driving");
    property p_zero; w_c3 && w_oe && !i_wdata[15] |=> $stable(o_ms_pad_oe_n[0]); endproperty
    a_zero: assert property (p_zero) else $error("zero bit changed direction");
    property p_ao_set; w_c2 && i_addr == 12'h010 && i_wdata[14] && o_ao_route[3:2] == 2'h0
        |=> !o_ao_pad_oe_n[1]; endproperty
    a_ao_set: assert property (p_ao_set) else $error("always-on pin not driving");
    property p_pull_dir; (w_c2 || w_c3) && w_oe |=> $stable(o_ms_pull_up) && $stable(o_ao_pull_up);
    endproperty
    a_pull_dir: assert property (p_pull_dir) else $error("pull moved with direction");
    property p_ao_pull; w_aon && i_addr == 12'h00c |=> o_ao_pull_up == ~$past(i_wdata[2:0]); endproperty
    a_ao_pull: assert property (p_ao_pull) else $error("always-on pull wrong");
    property p_route; o_ao_route[1:0] != 2'h0 |-> o_ao_pad_oe_n[0] == !i_periph_oe[0]
        && (!i_periph_oe[0] || o_ao_pad[0] == i_periph_out[0]); endproperty
    a_route: assert property (p_route) else $error("routed pad not under peripheral");
    property p_data; s_pad_steady ##0 s_read_data |=> o_rdata[15] == $past(i_ms_pad[0])
        && o_rdata[31:16] == 16'h0000; endproperty
    a_data: assert property (p_data) else $error("data read not pad level");
endmodule // mapc_chk

bind mapc_pin_ctrl mapc_chk u_chk (.*);

// *** mapc_pad_model.sv ***
// Pad model: outside drivers, pull resistors and floating lines
`timescale 1ns/1ns
module mapc_pad_model #(
    parameter int W = 4
) (
    input wire i_clk,
    input wire [W-1:0] i_drv, i_oe_n, i_pu, i_pd, i_ext_en, i_ext_val,
    output logic [W-1:0] o_level
);
    logic [W-1:0] float_pat = '0;
    // Unpulled, undriven lines wander so no stale level is read back
    always @(posedge i_clk) float_pat <= ~float_pat;
    // Chip drive first, then outside driver, then pulls in either direction
    always_comb
        for (int g = 0; g < W; g++)
            o_level[g] = !i_oe_n[g] ? i_drv[g] : i_ext_en[g] ? i_ext_val[g] :
                i_pu[g] ? 1'b1 : i_pd[g] ? 1'b0 : float_pat[g];
endmodule // mapc_pad_model

// *** tb.sv ***
// Self-checking testbench for the mixed and always-on pin control block
`timescale 1ns/1ns
module tb;
    logic i_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0;
    logic [1:0] i_sel = 0;
    logic [11:0] i_addr = 0;
    logic [31:0] i_wdata = 0, o_rdata;
    logic [3:0] i_ms_pad, o_ms_pad, o_ms_pad_oe_n, o_ms_analog_en, o_ms_pull_up, o_ms_pull_down;
    logic [3:0] ms_ext_en = 0;
    logic [2:0] ao_ext_en = 0;
    logic [2:0] i_ao_pad, o_ao_pad, o_ao_pad_oe_n, o_ao_pull_up, o_ao_wake_en, o_periph_in;
    logic [2:0] i_periph_out = 0, i_periph_oe = 0;
    logic [5:0] o_ao_route;
    logic [7:0] pulls [4] = '{8'h00, 8'h0f, 8'hf0, 8'h5a};
    int num_errors = 0, num_checks = 0;
    mapc_pin_ctrl uut (.*);
    mapc_pad_model #(.W(4)) u_ms (.i_clk(i_clk), .i_drv(o_ms_pad), .i_oe_n(o_ms_pad_oe_n),
        .i_pu(o_ms_pull_up), .i_pd(o_ms_pull_down), .i_ext_en(ms_ext_en), .i_ext_val(4'h0),
        .o_level(i_ms_pad));
    mapc_pad_model #(.W(3)) u_ao (.i_clk(i_clk), .i_drv(o_ao_pad), .i_oe_n(o_ao_pad_oe_n),
        .i_pu(o_ao_pull_up), .i_pd(3'h0), .i_ext_en(ao_ext_en), .i_ext_val(3'h0),
        .o_level(i_ao_pad));
    // 50 MHz clock
    initial forever #10 i_clk = ~i_clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One-cycle strobes; the extra edge keeps back-to-back calls clean
    task automatic wr(input logic [1:0] s, input logic [11:0] a, input logic [31:0] d);
        @(posedge i_clk);
        {i_sel, i_addr, i_wdata, i_wr} <= {s, a, d, 1'b1};
        @(posedge i_clk);
        i_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [1:0] s, input logic [11:0] a, input logic [31:0] e);
        @(posedge i_clk);
        {i_sel, i_addr, i_rd} <= {s, a, 1'b1};
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(posedge i_clk);
        #1 chk(o_rdata, e);
    endtask
    task automatic results;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge i_clk);
        i_rst <= 1'b0;
        #1;
        // Reset state of both pad groups and the register file
        chk({o_ms_analog_en, o_ms_pad_oe_n, o_ms_pull_up, o_ms_pull_down}, 16'hff00);
        chk({o_ao_pad_oe_n, o_ao_pull_up, o_ao_wake_en, o_ao_route}, 15'h7e40);
        rd(2'h2, 12'h000, 32'h0000000f);
        rd(2'h2, 12'h004, 32'h000000f0);
        rd(2'h2, 12'h010, 32'h00000001);
        wr(2'h3, 12'h000, 32'hffffffff);
        rd(2'h3, 12'h000, 32'h00000000);
        // Four pull patterns, per-bit mixes included
        foreach (pulls[i]) begin
            wr(2'h2, 12'h004, {24'h0, pulls[i]});
            chk({o_ms_pull_up, o_ms_pull_down}, {~pulls[i][7:4] & ~pulls[i][3:0],
                ~pulls[i][7:4] & pulls[i][3:0]});
        end
        // Mixed pin 0 digital output; pin 1 stays analog so its enable has no effect
        wr(2'h2, 12'h004, 32'h0);
        wr(2'h2, 12'h000, 32'he);
        wr(2'h1, 12'h004, 32'h8000);
        wr(2'h1, 12'h010, 32'hc000);
        chk({o_ms_pad_oe_n, o_ms_pad, o_ms_pull_up}, 12'he1f);
        wr(2'h1, 12'h014, 32'h0);
        chk(o_ms_pad_oe_n, 4'he);
        rd(2'h1, 12'h010, 32'hc000);
        repeat (6) @(posedge i_clk);
        rd(2'h1, 12'h000, 32'hf000);
        // Back to input with the outside world pulling pin 0 low
        @(posedge i_clk) ms_ext_en <= 4'h1;
        wr(2'h1, 12'h014, 32'h8000);
        chk(o_ms_pad_oe_n, 4'hf);
        repeat (6) @(posedge i_clk);
        rd(2'h1, 12'h000, 32'h7000);
        // Always-on pins 1 and 2 drive, pull-ups off there
        wr(2'h0, 12'h004, 32'h2000);
        wr(2'h0, 12'h010, 32'h6000);
        wr(2'h2, 12'h00c, 32'h6);
        chk({o_ao_pad_oe_n, o_ao_pad, o_ao_pull_up}, 9'h061);
        repeat (6) @(posedge i_clk);
        rd(2'h0, 12'h000, 32'ha000);
        wr(2'h0, 12'h014, 32'h4000);
        chk(o_ao_pad_oe_n, 3'h3);
        // Unpulled input pin 1 held low from outside reads back low
        @(posedge i_clk) ao_ext_en <= 3'h2;
        repeat (6) @(posedge i_clk);
        rd(2'h0, 12'h000, 32'ha000);
        // Hand pin 0 to a peripheral driving high, then back to the port
        @(posedge i_clk) {i_periph_oe, i_periph_out} <= 6'h09;
        wr(2'h2, 12'h008, 32'h1);
        chk({o_ao_pad_oe_n[0], o_ao_pad[0]}, 2'h1);
        repeat (6) @(posedge i_clk);
        chk(o_periph_in, 3'h1);
        @(posedge i_clk) i_periph_oe <= 3'h0;
        wr(2'h0, 12'h010, 32'h8000);
        chk(o_ao_pad_oe_n[0], 1'b1);
        repeat (6) @(posedge i_clk);
        chk(o_periph_in, 3'h1);
        wr(2'h2, 12'h008, 32'h0);
        chk({o_ao_pad_oe_n[0], o_ao_pad[0]}, 2'h0);
        results();
    end
endmodule // tb
